//--- logic/gate_driver_config_registers.v
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "gate_cfg_consts.vh"

module gate_driver_config_registers (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    // Driver control
    output wire [9:0]  driver_control_o,
    output reg         fault_clear_strobe_o,
    output wire        locked_o,
    // High-side drive
    output wire [3:0]  high_source_current_o,
    output wire [3:0]  high_sink_current_o,
    // Low-side drive
    output wire        cycle_by_cycle_o,
    output wire [1:0]  peak_drive_time_o,
    output wire [3:0]  low_source_current_o,
    output wire [3:0]  low_sink_current_o,
    // Overcurrent control
    output wire        retry_short_o,
    output wire [1:0]  dead_time_o,
    output wire [1:0]  overcurrent_response_o,
    output wire [1:0]  overcurrent_filter_time_o,
    output wire [3:0]  drain_source_threshold_o,
    output wire        cbc_clear_active_o,
    output wire        overcurrent_report_o,
    output wire        overcurrent_act_o,
    // Shunt amplifier
    output wire        amp_input_select_o,
    output wire        amp_half_reference_o,
    output wire        low_side_measure_ref_o,
    output wire [1:0]  amp_gain_select_o,
    output wire        sense_fault_disable_o,
    output wire        shunt_overcurrent_enable_o,
    output wire        phase_a_offset_cal_o,
    output wire        phase_b_offset_cal_o,
    output wire        phase_c_offset_cal_o,
    output wire [1:0]  sense_trip_threshold_o
);

    // ==========================================================
    // Storage
    reg  [10:0] driver_control;
    reg  [10:0] high_side_drive_setting;
    reg  [10:0] low_side_drive_setting;
    reg  [10:0] overcurrent_control;
    reg  [10:0] shunt_amplifier_control;

    wire [3:0]  reg_index;
    wire        request;
    wire        mapped;
    wire        write_low;
    wire        write_high;
    wire [10:0] wr_mask;
    wire [10:0] wr_data;
    wire        locked;
    wire [2:0]  lock_field;
    wire [2:0]  next_lock;
    wire [10:0] next_high;
    reg  [10:0] read_value;

    assign reg_index  = wb_adr_i[5:2];
    assign request    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped     = (reg_index >= `IDX_DRIVER_CONTROL) && (reg_index <= `IDX_SHUNT_AMP);
    // Byte lanes 0 and 1 carry the 11-bit registers
    assign write_low  = request && mapped && wb_we_i && wb_sel_i[0];
    assign write_high = request && mapped && wb_we_i && wb_sel_i[1];
    assign wr_mask    = {{3{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_data    = wb_dat_i[10:0];

    assign lock_field = high_side_drive_setting[`LOCK_MSB:`LOCK_LSB];
    assign locked     = (lock_field == `LOCK_CODE);

    // Lock field only moves on its two codes, so it always holds one of them
    assign next_lock = (!locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `LOCK_CODE) ? `LOCK_CODE :
                       (locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `UNLOCK_CODE) ? `UNLOCK_CODE :
                       lock_field;
    assign next_high = {next_lock,
                        locked ? high_side_drive_setting[7:0] : wr_data[7:0]};

    // ==========================================================
    // Register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            driver_control          <= `RST_DRIVER_CONTROL;
            high_side_drive_setting <= {`UNLOCK_CODE, 8'hFF};
            low_side_drive_setting  <= `RST_LOW_SIDE;
            overcurrent_control     <= `RST_OVERCURRENT;
            shunt_amplifier_control <= `RST_SHUNT_AMP;
            fault_clear_strobe_o    <= 1'b0;
        end else begin
            fault_clear_strobe_o <= 1'b0;
            if (write_low || write_high) begin
                if (reg_index == `IDX_DRIVER_CONTROL) begin
                    // Bits 0-2 stay writable while locked; clear bit never stores
                    if (locked) begin
                        driver_control <= (driver_control & ~(wr_mask & `DC_LOCKFREE_MASK))
                                        | (wr_data & wr_mask & `DC_LOCKFREE_MASK & 11'h7FE);
                    end else begin
                        driver_control <= ((driver_control & ~wr_mask) | (wr_data & wr_mask)) & 11'h7FE;
                    end
                    fault_clear_strobe_o <= write_low && wr_data[`DC_CLEAR_BIT];
                end else if (reg_index == `IDX_HIGH_SIDE) begin
                    high_side_drive_setting <= (high_side_drive_setting & ~wr_mask) | (next_high & wr_mask);
                end else if (locked) begin
                    // Writes to other registers are dropped but still acknowledged
                end else if (reg_index == `IDX_LOW_SIDE) begin
                    low_side_drive_setting <= (low_side_drive_setting & ~wr_mask) | (wr_data & wr_mask);
                end else if (reg_index == `IDX_OVERCURRENT) begin
                    overcurrent_control <= (overcurrent_control & ~wr_mask) | (wr_data & wr_mask);
                end else begin
                    shunt_amplifier_control <= (shunt_amplifier_control & ~wr_mask) | (wr_data & wr_mask);
                end
            end
        end
    end

    // ==========================================================
    // Read decode
    always @* begin
        if (reg_index == `IDX_DRIVER_CONTROL) begin
            read_value = driver_control;
        end else if (reg_index == `IDX_HIGH_SIDE) begin
            read_value = high_side_drive_setting;
        end else if (reg_index == `IDX_LOW_SIDE) begin
            read_value = low_side_drive_setting;
        end else if (reg_index == `IDX_OVERCURRENT) begin
            read_value = overcurrent_control;
        end else if (reg_index == `IDX_SHUNT_AMP) begin
            // Input select reads back the forced reference bit
            read_value = shunt_amplifier_control | {2'b00, shunt_amplifier_control[`SA_INPUT_BIT], 8'h00};
        end else begin
            read_value = 11'h000;
        end
    end

    // One-cycle answer; unmapped addresses get err instead of ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= request && mapped;
            wb_err_o <= request && !mapped;
            if (request && mapped && !wb_we_i) begin
                wb_dat_o <= {21'h00_0000, read_value};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Decoded controls
    assign driver_control_o          = driver_control[10:1];
    assign locked_o                  = locked;
    assign high_source_current_o     = high_side_drive_setting[`HS_SOURCE_MSB:`HS_SOURCE_LSB];
    assign high_sink_current_o       = high_side_drive_setting[`HS_SINK_MSB:`HS_SINK_LSB];
    assign cycle_by_cycle_o          = low_side_drive_setting[`LS_CBC_BIT];
    assign peak_drive_time_o         = low_side_drive_setting[`LS_PEAK_TIME_MSB:`LS_PEAK_TIME_LSB];
    assign low_source_current_o      = low_side_drive_setting[`HS_SOURCE_MSB:`HS_SOURCE_LSB];
    assign low_sink_current_o        = low_side_drive_setting[`HS_SINK_MSB:`HS_SINK_LSB];
    assign retry_short_o             = overcurrent_control[`OC_RETRY_BIT];
    assign dead_time_o               = overcurrent_control[`OC_DEAD_MSB:`OC_DEAD_LSB];
    assign overcurrent_response_o    = overcurrent_control[`OC_MODE_MSB:`OC_MODE_LSB];
    assign overcurrent_filter_time_o = overcurrent_control[`OC_FILTER_MSB:`OC_FILTER_LSB];
    assign drain_source_threshold_o  = overcurrent_control[`OC_VDS_MSB:`OC_VDS_LSB];
    // Cycle-by-cycle clearing is meaningless outside auto-retry
    assign cbc_clear_active_o   = cycle_by_cycle_o && (overcurrent_response_o == `OCR_RETRY);
    assign overcurrent_report_o = (overcurrent_response_o != `OCR_IGNORE);
    assign overcurrent_act_o    = (overcurrent_response_o == `OCR_LATCH)
                               || (overcurrent_response_o == `OCR_RETRY);
    assign amp_input_select_o     = shunt_amplifier_control[`SA_INPUT_BIT];
    assign amp_half_reference_o   = shunt_amplifier_control[`SA_VREF_BIT];
    assign low_side_measure_ref_o = shunt_amplifier_control[`SA_LSREF_BIT]
                                 || shunt_amplifier_control[`SA_INPUT_BIT];
    assign amp_gain_select_o      = shunt_amplifier_control[`SA_GAIN_MSB:`SA_GAIN_LSB];
    assign sense_fault_disable_o  = shunt_amplifier_control[`SA_DIS_BIT];
    assign shunt_overcurrent_enable_o = !shunt_amplifier_control[`SA_DIS_BIT];
    assign phase_a_offset_cal_o   = shunt_amplifier_control[`SA_CAL_A_BIT];
    assign phase_b_offset_cal_o   = shunt_amplifier_control[`SA_CAL_B_BIT];
    assign phase_c_offset_cal_o   = shunt_amplifier_control[`SA_CAL_C_BIT];
    assign sense_trip_threshold_o = shunt_amplifier_control[`SA_SEN_MSB:`SA_SEN_LSB];

endmodule

//--- logic/gate_cfg_consts.vh
`ifndef GATE_CFG_CONSTS_VH
`define GATE_CFG_CONSTS_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_DRIVER_CONTROL   4'h2
`define IDX_HIGH_SIDE        4'h3
`define IDX_LOW_SIDE         4'h4
`define IDX_OVERCURRENT      4'h5
`define IDX_SHUNT_AMP        4'h6
// ==========================================================
// Lock field
`define LOCK_MSB             10
`define LOCK_LSB             8
`define LOCK_CODE            3'h6
`define UNLOCK_CODE          3'h3
// ==========================================================
// Field positions
`define HS_SOURCE_MSB        7
`define HS_SOURCE_LSB        4
`define HS_SINK_MSB          3
`define HS_SINK_LSB          0
`define LS_CBC_BIT           10
`define LS_PEAK_TIME_MSB     9
`define LS_PEAK_TIME_LSB     8
`define OC_RETRY_BIT         10
`define OC_DEAD_MSB          9
`define OC_DEAD_LSB          8
`define OC_MODE_MSB          7
`define OC_MODE_LSB          6
`define OC_FILTER_MSB        5
`define OC_FILTER_LSB        4
`define OC_VDS_MSB           3
`define OC_VDS_LSB           0
`define SA_INPUT_BIT         10
`define SA_VREF_BIT          9
`define SA_LSREF_BIT         8
`define SA_GAIN_MSB          7
`define SA_GAIN_LSB          6
`define SA_DIS_BIT           5
`define SA_CAL_A_BIT         4
`define SA_CAL_B_BIT         3
`define SA_CAL_C_BIT         2
`define SA_SEN_MSB           1
`define SA_SEN_LSB           0
`define DC_CLEAR_BIT         0
`define DC_LOCKFREE_MASK     11'h007
// ==========================================================
// Reset values
`define RST_DRIVER_CONTROL   11'h000
`define RST_HIGH_SIDE        11'h3FF
`define RST_LOW_SIDE         11'h7FF
`define RST_OVERCURRENT      11'h169
`define RST_SHUNT_AMP        11'h283
// ==========================================================
// Overcurrent response codes
`define OCR_LATCH            2'h0
`define OCR_RETRY            2'h1
`define OCR_REPORT           2'h2
`define OCR_IGNORE           2'h3
`endif

//--- test/gate_cfg_checker_sva.sv
`timescale 1ns/1ps
module gate_cfg_checker (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Wishbone slave
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [5:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    // Control outputs
    input wire        fault_clear_strobe_o,
    input wire        locked_o,
    input wire        amp_input_select_o,
    input wire        low_side_measure_ref_o,
    input wire        cycle_by_cycle_o,
    input wire        cbc_clear_active_o,
    input wire [1:0]  overcurrent_response_o,
    input wire        overcurrent_report_o,
    input wire        overcurrent_act_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Helpers
    wire       take    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [3:0] idx     = wb_adr_i[5:2];
    wire       mapped  = (idx >= 4'h2) && (idx <= 4'h6);
    wire       lock_wr = take & wb_we_i & (idx == 4'h3) & wb_sel_i[1];
    sequence s_ack_once;
        wb_ack_o && !wb_err_o ##1 !wb_ack_o;
    endsequence
    sequence s_err_once;
        wb_err_o && !wb_ack_o ##1 !wb_err_o;
    endsequence
    sequence s_clear_take;
        take && wb_we_i && idx == 4'h2 && wb_sel_i[0] && wb_dat_i[0];
    endsequence
    // ==========================================================
    // Properties
    property p_ack_mapped; take && mapped |-> ##1 s_ack_once; endproperty
    property p_err_unmapped; take && !mapped |-> ##1 s_err_once; endproperty
    property p_read_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:11] == 21'h0; endproperty
    property p_lock_set; lock_wr && wb_dat_i[10:8] == 3'h6 |-> ##1 locked_o; endproperty
    property p_lock_hold; locked_o && !(lock_wr && wb_dat_i[10:8] == 3'h3) |=> locked_o; endproperty
    property p_unlock; lock_wr && wb_dat_i[10:8] == 3'h3 |-> ##1 !locked_o; endproperty
    property p_stay_open; !locked_o && !(lock_wr && wb_dat_i[10:8] == 3'h6) |=> !locked_o; endproperty
    property p_clear; s_clear_take |-> ##1 (fault_clear_strobe_o && wb_ack_o) ##1 !fault_clear_strobe_o; endproperty
    property p_ref_forced; amp_input_select_o |-> low_side_measure_ref_o; endproperty
    property p_cbc; cbc_clear_active_o == (cycle_by_cycle_o && overcurrent_response_o == 2'h1); endproperty
    property p_mode;
        overcurrent_report_o == (overcurrent_response_o != 2'h3) && overcurrent_act_o == !overcurrent_response_o[1];
    endproperty
    a_ack_mapped: assert property (p_ack_mapped) else $error("mapped access not acked once");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not errored");
    a_read_upper: assert property (p_read_upper) else $error("read data upper bits set");
    a_lock_set: assert property (p_lock_set) else $error("lock code did not lock");
    a_lock_hold: assert property (p_lock_hold) else $error("lock lost without unlock code");
    a_unlock: assert property (p_unlock) else $error("unlock code did not unlock");
    a_stay_open: assert property (p_stay_open) else $error("locked without lock code");
    a_clear: assert property (p_clear) else $error("fault clear pulse wrong");
    a_ref_forced: assert property (p_ref_forced) else $error("reference bit not forced");
    a_cbc: assert property (p_cbc) else $error("cycle clear active wrong");
    a_mode: assert property (p_mode) else $error("response decode wrong");
endmodule

bind gate_driver_config_registers gate_cfg_checker chk_i (.*);

//--- test/wb_host.sv
`timescale 1ns/1ps
// ==========================================================
// Classic Wishbone master standing in for the motor controller
module wb_host (
    // Clock and answer
    input  wire        clk_i,
    input  wire        ack_i,
    input  wire        err_i,
    input  wire [31:0] rdat_i,
    // Request
    output logic       cyc_o = 1'b0,
    output logic       stb_o = 1'b0,
    output logic       we_o = 1'b0,
    output logic [5:0] adr_o = 6'h00,
    output logic [3:0] sel_o = 4'h0,
    output logic [31:0] dat_o = 32'h0000_0000
);
    logic timed_out = 1'b0;
    task access(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d,
                output logic [31:0] q, output logic e);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack_i === 1'b1 || err_i === 1'b1) && n < 32);
        timed_out = !(ack_i === 1'b1 || err_i === 1'b1);
        q = rdat_i;
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released address and data lines show no stale value
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

//--- test/gate_driver_config_registers_tb.sv
`timescale 1ns/1ps
module gate_driver_config_registers_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wire         cyc, stb, we, ack, err, locked, cbc, report, act, low_side_measure_ref, retry;
    wire  [5:0]  adr;
    wire  [3:0]  sel, hs_src;
    wire  [1:0]  dead;
    wire  [31:0] wdat, rdat;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [31:0] q;
    logic        e;
    always #4 clk_i = ~clk_i;
    wb_host host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                  .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    gate_driver_config_registers uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .driver_control_o(), .fault_clear_strobe_o(), .locked_o(locked),
        .high_source_current_o(hs_src), .high_sink_current_o(), .cycle_by_cycle_o(), .peak_drive_time_o(),
        .low_source_current_o(), .low_sink_current_o(), .retry_short_o(retry), .dead_time_o(dead),
        .overcurrent_response_o(), .overcurrent_filter_time_o(), .drain_source_threshold_o(),
        .cbc_clear_active_o(cbc), .overcurrent_report_o(report), .overcurrent_act_o(act),
        .amp_input_select_o(), .amp_half_reference_o(), .low_side_measure_ref_o(low_side_measure_ref),
        .amp_gain_select_o(), .sense_fault_disable_o(), .shunt_overcurrent_enable_o(),
        .phase_a_offset_cal_o(), .phase_b_offset_cal_o(), .phase_c_offset_cal_o(), .sense_trip_threshold_o());
    // ==========================================================
    // Tasks
    task test_done();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task acc(input logic w, input logic [3:0] i, input logic [10:0] d, input logic [3:0] s);
        host.access(w, {i, 2'b00}, s, {21'h0, d}, q, e);
        if (host.timed_out) begin
            n_errors++;
            test_done();
        end
    endtask
    task wr(input logic [3:0] i, input logic [10:0] d);
        acc(1'b1, i, d, 4'h3);
    endtask
    task rd(input logic [3:0] i, input logic [10:0] x);
        acc(1'b0, i, 11'h000, 4'hf);
        chk(q, {21'h0, x});
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h2, 11'h000);
        rd(4'h3, 11'h3ff);
        rd(4'h4, 11'h7ff);
        rd(4'h5, 11'h169);
        rd(4'h6, 11'h283);
        chk(32'(hs_src), 32'h0000_000f);
        wr(4'h4, 11'h6a5);
        rd(4'h4, 11'h6a5);
        // Cycle clearing is set above, so every response code shows its decode
        for (int m = 0; m < 4; m++) begin
            wr(4'h5, {3'b111, m[1:0], 6'h00});
            chk(32'({cbc, report, act}), 32'({m == 1, m != 3, m < 2}));
        end
        chk(32'({retry, dead}), 32'h0000_0007);
        wr(4'h6, 11'h400);
        rd(4'h6, 11'h500);
        chk(32'(low_side_measure_ref), 32'h0000_0001);
        wr(4'h6, 11'h000);
        rd(4'h6, 11'h000);
        wr(4'h3, 11'h512);
        rd(4'h3, 11'h312);
        wr(4'h3, 11'h612);
        chk(32'(locked), 32'h0000_0001);
        wr(4'h4, 11'h000);
        rd(4'h4, 11'h6a5);
        wr(4'h2, 11'h7fe);
        rd(4'h2, 11'h006);
        wr(4'h3, 11'h5ff);
        rd(4'h3, 11'h612);
        wr(4'h3, 11'h312);
        rd(4'h3, 11'h312);
        wr(4'h2, 11'h001);
        rd(4'h2, 11'h000);
        acc(1'b1, 4'h4, 11'h000, 4'h0);
        rd(4'h4, 11'h6a5);
        acc(1'b0, 4'hf, 11'h000, 4'hf);
        chk(32'(e), 32'h0000_0001);
        test_done();
    end
endmodule
